// ---- include/breaker_fail_pkg.sv ----
// Constants shared by the breaker failure supervision logic.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package breaker_fail_pkg;

  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int N_EV      = 8;
  localparam int LOG_DEPTH = 12;
  localparam int PTR_W     = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL         = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RETRIP_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CBF_DELAY    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT_SELECT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COUNT_CLEAR  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CNT_RETRIP   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT_CBF      = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CNT_START    = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CNT_BLOCK    = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_LOG_INDEX    = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_LOG_DATA     = 8'h34;

  // Control fields
  localparam int CTRL_CRIT_LSB  = 0;
  localparam int CTRL_RETRIP_EN = 2;
  localparam int CTRL_RES_SEL   = 3;
  localparam int CTRL_W         = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h4;

  typedef enum logic [1:0] {
    CRIT_CURRENT  = 2'h0,
    CRIT_CUR_AND  = 2'h1,
    CRIT_CUR_OR   = 2'h2,
    CRIT_DIGITAL  = 2'h3
  } crit_t;

  // Event indices, also the order of sticky and mask bits
  localparam int EV_START  = 0;
  localparam int EV_RETRIP = 1;
  localparam int EV_CBF    = 2;
  localparam int EV_BLOCK  = 3;
  localparam int EV_MON    = 4;
  localparam int EV_SIGNAL = 5;
  localparam int EV_PHASE  = 6;
  localparam int EV_RES    = 7;

  // Two select bits per event: ON store, OFF store
  localparam logic [2*N_EV-1:0] EV_SEL_RST = 16'hFFFF;

  // Delay defaults, converted to processing ticks
  localparam int TICK_US           = 5000;
  localparam int RETRIP_DEFAULT_US = 100000;
  localparam int CBF_DEFAULT_US    = 200000;
  localparam int RETRIP_RST_TICKS  = RETRIP_DEFAULT_US / TICK_US;
  localparam int CBF_RST_TICKS     = CBF_DEFAULT_US / TICK_US;

  // Log read window
  localparam int LOG_WORD_LSB = 4;
  localparam int LOG_IDX_W    = 7;
  localparam logic [2:0] LOG_WORD_TIME  = 3'h0;
  localparam logic [2:0] LOG_WORD_ID    = 3'h1;
  localparam logic [2:0] LOG_WORD_CURR  = 3'h2;
  localparam logic [2:0] LOG_WORD_REMAIN = 3'h3;

  // Status layout
  localparam int STAT_FILL_LSB = 8;
  localparam int STAT_PTR_LSB  = 12;

endpackage

// ---- core/breaker_failure_timer_logic.sv ----
// Breaker failure supervision: pick-up criteria, retrip and failure timers,
// event stream, occurrence counters and a rolling record log.
// Assumes pin inputs are asynchronous, tick and process data are on clk.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module breaker_failure_timer_logic
  import breaker_fail_pkg::*;
#(
  parameter int CNT_W = 20,
  parameter int CTR_W = 16
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Wishbone slave
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADDR_W-1:0] wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [DATA_W-1:0] wb_dat_w,
  output logic      [DATA_W-1:0] wb_dat_r,
  output logic                   wb_ack,
  // Protection pins
  input  wire logic              phase_over,
  input  wire logic              residual_over,
  input  wire logic              trip_monitor,
  input  wire logic              digital_in,
  input  wire logic              block_in,
  // Process data
  input  wire logic              cycle_tick,
  input  wire logic [31:0]       time_stamp,
  input  wire logic [15:0]       phase_max_current,
  input  wire logic [15:0]       residual_input_one,
  input  wire logic [15:0]       residual_input_two,
  input  wire logic [2:0]        setting_group,
  // Trip outputs
  output logic                   start_output,
  output logic                   blocked_output,
  output logic                   retrip_output,
  output logic                   breaker_fail_output,
  // Event stream
  output logic                   event_valid,
  output logic [2:0]             event_id,
  output logic                   event_on,
  output logic                   event_store,
  output logic [31:0]            event_time,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0]  id;
    logic [2:0]  group;
    logic [15:0] phase;
    logic [15:0] resid;
    logic [15:0] t_retrip;
    logic [15:0] t_cbf;
  } rec_t;

  typedef struct packed {
    logic [4:0]                  sync1;
    logic [4:0]                  sync2;
    logic [CTRL_W-1:0]           ctrl;
    logic [CNT_W-1:0]            retrip_delay;
    logic [CNT_W-1:0]            cbf_delay;
    logic [2*N_EV-1:0]           ev_sel;
    logic [N_EV-1:0]             irq_stat;
    logic [N_EV-1:0]             irq_mask;
    logic [3:0][CTR_W-1:0]       occ;
    logic [LOG_IDX_W-1:0]        log_index;
    logic [CNT_W-1:0]            rt_cnt;
    logic [CNT_W-1:0]            cb_cnt;
    logic                        start;
    logic                        blocked;
    logic                        retrip;
    logic                        cbf;
    logic [N_EV-1:0]             cond_prev;
    logic [N_EV-1:0]             pend_on;
    logic [N_EV-1:0]             pend_off;
    logic [31:0]                 tick_time;
    logic                        ev_valid;
    logic [2:0]                  ev_id;
    logic                        ev_on;
    logic                        ev_store;
    logic [31:0]                 ev_time;
    rec_t [LOG_DEPTH-1:0]        log;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            fill;
    logic                        ack;
    logic [DATA_W-1:0]           rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   rst_meta_q;
  logic   rst_sync_q;

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [3:0]        sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [15:0] remain(input logic [CNT_W-1:0] delay,
                                         input logic [CNT_W-1:0] cnt);
    logic [CNT_W-1:0] d;
    d = (cnt >= delay) ? '0 : delay - cnt;
    return (d > CNT_W'(16'hFFFF)) ? 16'hFFFF : d[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic              ph;
  logic              res;
  logic              mon;
  logic              di;
  logic              blk;
  logic              cur;
  logic              pickup;
  logic              go;
  logic [N_EV-1:0]   cond;
  logic [N_EV-1:0]   rise;
  logic [N_EV-1:0]   fall;
  logic              found;
  logic [2:0]        pick_id;
  logic              pick_on;
  logic [15:0]       resid_sel;
  logic [DATA_W-1:0] wr_word;
  logic              wr_en;
  rec_t              rec;
  logic [PTR_W-1:0]  rd_entry;

  always_comb
  begin
    s_d = s_q;
    found = 1'b0;
    pick_id = 3'h0;
    pick_on = 1'b0;
    rec = '0;
    wr_word = '0;

    s_d.sync1 = {block_in, digital_in, trip_monitor, residual_over, phase_over};
    s_d.sync2 = s_q.sync1;
    ph  = s_q.sync2[0];
    res = s_q.sync2[1];
    mon = s_q.sync2[2];
    di  = s_q.sync2[3];
    blk = s_q.sync2[4];
    cur = ph | res;

    // Pick-up per criterion
    case (crit_t'(s_q.ctrl[CTRL_CRIT_LSB +: 2]))
      CRIT_CURRENT: pickup = cur;
      CRIT_CUR_AND: pickup = cur & mon;
      CRIT_CUR_OR:  pickup = cur | mon;
      CRIT_DIGITAL: pickup = di;
      default:      pickup = 1'b0;
    endcase

    // Blocked pick-up never times and drops an earlier start
    go = pickup & ~blk;
    s_d.start   = go;
    s_d.blocked = pickup & blk;

    // Both timers from one pick-up; cleared the cycle it drops
    if (!go)
    begin
      s_d.rt_cnt = '0;
      s_d.cb_cnt = '0;
    end
    else if (cycle_tick)
    begin
      if (s_q.rt_cnt < s_q.retrip_delay)
        s_d.rt_cnt = s_q.rt_cnt + 1'b1;
      if (s_q.cb_cnt < s_q.cbf_delay)
        s_d.cb_cnt = s_q.cb_cnt + 1'b1;
    end
    s_d.retrip = go & s_q.ctrl[CTRL_RETRIP_EN]
               & (s_q.rt_cnt >= s_q.retrip_delay);
    s_d.cbf = go & (s_q.cb_cnt >= s_q.cbf_delay);

    // Watched conditions
    cond = '0;
    cond[EV_START]  = s_q.start;
    cond[EV_RETRIP] = s_q.retrip;
    cond[EV_CBF]    = s_q.cbf;
    cond[EV_BLOCK]  = s_q.blocked;
    cond[EV_MON]    = mon;
    cond[EV_SIGNAL] = di;
    cond[EV_PHASE]  = ph;
    cond[EV_RES]    = res;
    rise = cycle_tick ? (cond & ~s_q.cond_prev) : '0;
    fall = cycle_tick ? (~cond & s_q.cond_prev) : '0;

    ////////////////////////////////////////////////////////////////////
    // Bus access, applied before hardware sets so that sets win

    s_d.ack = wb_cyc & wb_stb & ~s_q.ack;
    wr_en = wb_cyc & wb_stb & wb_we & s_q.ack;
    if (wr_en)
    begin
      case ({wb_adr[ADDR_W-1:2], 2'b00})
        OFS_CTRL:
        begin
          wr_word = merge(DATA_W'(s_q.ctrl), wb_dat_w, wb_sel);
          s_d.ctrl = wr_word[CTRL_W-1:0];
        end
        OFS_RETRIP_DELAY:
        begin
          wr_word = merge(DATA_W'(s_q.retrip_delay), wb_dat_w, wb_sel);
          s_d.retrip_delay = wr_word[CNT_W-1:0];
        end
        OFS_CBF_DELAY:
        begin
          wr_word = merge(DATA_W'(s_q.cbf_delay), wb_dat_w, wb_sel);
          s_d.cbf_delay = wr_word[CNT_W-1:0];
        end
        OFS_EVENT_SELECT:
        begin
          wr_word = merge(DATA_W'(s_q.ev_sel), wb_dat_w, wb_sel);
          s_d.ev_sel = wr_word[2*N_EV-1:0];
        end
        OFS_IRQ_STATUS:
        begin
          if (wb_sel[0])
            s_d.irq_stat = s_q.irq_stat & ~wb_dat_w[N_EV-1:0];
        end
        OFS_IRQ_MASK:
        begin
          if (wb_sel[0])
            s_d.irq_mask = wb_dat_w[N_EV-1:0];
        end
        OFS_COUNT_CLEAR:
        begin
          for (int k = 0; k < 4; k++)
          begin
            if (wb_sel[0] && wb_dat_w[k])
              s_d.occ[k] = '0;
          end
        end
        OFS_LOG_INDEX:
        begin
          if (wb_sel[0])
            s_d.log_index = wb_dat_w[LOG_IDX_W-1:0];
        end
        default:
        begin
          s_d.ack = 1'b0;
        end
      endcase
      s_d.ack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Edge capture once per tick

    if (cycle_tick)
    begin
      s_d.cond_prev = cond;
      s_d.tick_time = time_stamp;
    end
    s_d.irq_stat = s_d.irq_stat | rise;
    if (rise[EV_RETRIP])
      s_d.occ[0] = s_d.occ[0] + 1'b1;
    if (rise[EV_CBF])
      s_d.occ[1] = s_d.occ[1] + 1'b1;
    if (rise[EV_START])
      s_d.occ[2] = s_d.occ[2] + 1'b1;
    if (rise[EV_BLOCK])
      s_d.occ[3] = s_d.occ[3] + 1'b1;

    // One event out per cycle, ON before OFF, lowest index first
    for (int i = N_EV - 1; i >= 0; i--)
    begin
      if (s_q.pend_off[i])
      begin
        found = 1'b1;
        pick_id = 3'(i);
        pick_on = 1'b0;
      end
    end
    for (int i = N_EV - 1; i >= 0; i--)
    begin
      if (s_q.pend_on[i])
      begin
        found = 1'b1;
        pick_id = 3'(i);
        pick_on = 1'b1;
      end
    end
    s_d.ev_valid = found;
    if (found)
    begin
      s_d.ev_id = pick_id;
      s_d.ev_on = pick_on;
      s_d.ev_time = s_q.tick_time;
      s_d.ev_store = s_q.ev_sel[{pick_id, ~pick_on}];
      if (pick_on)
        s_d.pend_on[pick_id] = 1'b0;
      else
        s_d.pend_off[pick_id] = 1'b0;
    end
    s_d.pend_on  = s_d.pend_on | rise;
    s_d.pend_off = s_d.pend_off | fall;

    ////////////////////////////////////////////////////////////////////
    // Record log

    resid_sel = s_q.ctrl[CTRL_RES_SEL] ? residual_input_two : residual_input_one;
    if (found && pick_on)
    begin
      rec.stamp    = s_q.tick_time;
      rec.id       = pick_id;
      rec.group    = setting_group;
      rec.phase    = phase_max_current;
      rec.resid    = resid_sel;
      rec.t_retrip = remain(s_q.retrip_delay, s_q.rt_cnt);
      rec.t_cbf    = remain(s_q.cbf_delay, s_q.cb_cnt);
      s_d.log[s_q.wr_ptr] = rec;
      s_d.wr_ptr = (s_q.wr_ptr == PTR_W'(LOG_DEPTH - 1)) ? '0
                 : s_q.wr_ptr + 1'b1;
      if (s_q.fill != PTR_W'(LOG_DEPTH))
        s_d.fill = s_q.fill + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, taken with the ack

    rd_entry = s_q.log_index[PTR_W-1:0];
    s_d.rdata = '0;
    case ({wb_adr[ADDR_W-1:2], 2'b00})
      OFS_CTRL:         s_d.rdata = DATA_W'(s_q.ctrl);
      OFS_RETRIP_DELAY: s_d.rdata = DATA_W'(s_q.retrip_delay);
      OFS_CBF_DELAY:    s_d.rdata = DATA_W'(s_q.cbf_delay);
      OFS_EVENT_SELECT: s_d.rdata = DATA_W'(s_q.ev_sel);
      OFS_STATUS:
      begin
        s_d.rdata[N_EV-1:0] = cond;
        s_d.rdata[STAT_FILL_LSB +: PTR_W] = s_q.fill;
        s_d.rdata[STAT_PTR_LSB +: PTR_W] = s_q.wr_ptr;
      end
      OFS_IRQ_STATUS:   s_d.rdata = DATA_W'(s_q.irq_stat);
      OFS_IRQ_MASK:     s_d.rdata = DATA_W'(s_q.irq_mask);
      OFS_CNT_RETRIP:   s_d.rdata = DATA_W'(s_q.occ[0]);
      OFS_CNT_CBF:      s_d.rdata = DATA_W'(s_q.occ[1]);
      OFS_CNT_START:    s_d.rdata = DATA_W'(s_q.occ[2]);
      OFS_CNT_BLOCK:    s_d.rdata = DATA_W'(s_q.occ[3]);
      OFS_LOG_INDEX:    s_d.rdata = DATA_W'(s_q.log_index);
      OFS_LOG_DATA:
      begin
        if (rd_entry < PTR_W'(LOG_DEPTH))
        begin
          case (s_q.log_index[LOG_WORD_LSB +: 3])
            LOG_WORD_TIME:   s_d.rdata = s_q.log[rd_entry].stamp;
            LOG_WORD_ID:     s_d.rdata = {24'h0, 2'h0, s_q.log[rd_entry].group,
                                          s_q.log[rd_entry].id};
            LOG_WORD_CURR:   s_d.rdata = {s_q.log[rd_entry].resid,
                                          s_q.log[rd_entry].phase};
            LOG_WORD_REMAIN: s_d.rdata = {s_q.log[rd_entry].t_cbf,
                                          s_q.log[rd_entry].t_retrip};
            default:         s_d.rdata = '0;
          endcase
        end
      end
      default:          s_d.rdata = '0;
    endcase
    if (!s_d.ack)
      s_d.rdata = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q              <= '0;
      s_q.ctrl         <= CTRL_RST;
      s_q.retrip_delay <= CNT_W'(RETRIP_RST_TICKS);
      s_q.cbf_delay    <= CNT_W'(CBF_RST_TICKS);
      s_q.ev_sel       <= EV_SEL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_r            = s_q.rdata;
  assign wb_ack              = s_q.ack;
  assign start_output        = s_q.start;
  assign blocked_output      = s_q.blocked;
  assign retrip_output       = s_q.retrip;
  assign breaker_fail_output = s_q.cbf;
  assign event_valid         = s_q.ev_valid;
  assign event_id            = s_q.ev_id;
  assign event_on            = s_q.ev_on;
  assign event_store         = s_q.ev_store;
  assign event_time          = s_q.ev_time;
  assign irq                 = |(s_q.irq_stat & s_q.irq_mask);

endmodule

// ---- bench/breaker_fail_properties.sv ----
// Port checker: bus answer, output timing, event framing.
// Assumes it is bound into the design top, one clock domain.
`timescale 1ns/1ns
module breaker_fail_properties
  import breaker_fail_pkg::*;
(
  // Clock, reset, bus
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              wb_cyc,
  input wire logic              wb_stb,
  input wire logic              wb_ack,
  input wire logic [DATA_W-1:0] wb_dat_r,
  // Pins and tick
  input wire logic              phase_over,
  input wire logic              residual_over,
  input wire logic              trip_monitor,
  input wire logic              digital_in,
  input wire logic              cycle_tick,
  input wire logic [31:0]       time_stamp,
  // Outputs
  input wire logic              start_output,
  input wire logic              blocked_output,
  input wire logic              retrip_output,
  input wire logic              breaker_fail_output,
  input wire logic              event_valid,
  input wire logic [31:0]       event_time
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Every criterion needs at least one of these pins
  wire logic pins_any = phase_over | residual_over | trip_monitor | digital_in;
  ////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not answered next cycle");
  rdata_idle_a: assert property (!wb_ack |-> wb_dat_r == '0)
    else $error("read data outside ack cycle");
  timed_start_a: assert property (
    breaker_fail_output || retrip_output |-> start_output)
    else $error("timed output without start");
  start_block_a: assert property (!(start_output && blocked_output))
    else $error("start and blocked together");
  fail_tick_a: assert property (
    $rose(breaker_fail_output) |-> $past(cycle_tick, 2) || !$past(start_output))
    else $error("failure output rose off tick");
  idle_clear_a: assert property (
    (!pins_any) [*5] |-> !start_output && !retrip_output && !breaker_fail_output)
    else $error("outputs stay without pick-up");
  start_delay_a: assert property ($rose(start_output) |-> $past(pins_any, 3))
    else $error("start without pin three cycles before");
  // Tick edge sets the pending bits; the first event registers one edge later
  event_tick_a: assert property ($rose(event_valid) |-> $past(cycle_tick, 2))
    else $error("event burst not after tick");
  event_time_a: assert property (
    event_valid && $past(cycle_tick, 2) |-> event_time == $past(time_stamp, 2))
    else $error("event time not tick stamp");
  event_burst_a: assert property (event_valid [*8] |=> !event_valid)
    else $error("more than eight events per tick");
  cover property ($rose(breaker_fail_output));
  cover property ($rose(retrip_output));
  cover property ($rose(blocked_output));
  cover property (event_valid [*2]);
endmodule
bind breaker_failure_timer_logic breaker_fail_properties i_breaker_fail_properties
(
  .clk, .rstn, .wb_cyc, .wb_stb, .wb_ack, .wb_dat_r, .phase_over, .residual_over,
  .trip_monitor, .digital_in, .cycle_tick, .time_stamp, .start_output, .blocked_output,
  .retrip_output, .breaker_fail_output, .event_valid, .event_time
);

// ---- bench/breaker_fail_partner.sv ----
// Upstream protection model: pick-up pins, processing tick, process data.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ns
module breaker_fail_partner
  import breaker_fail_pkg::*;
(
  // Bench requests
  input  wire logic        clk,
  input  wire logic        tick_req,
  input  wire logic [4:0]  pin_req,
  // Pins and process data
  output logic      [4:0]  pins,
  output logic             cycle_tick,
  output logic      [31:0] time_stamp,
  output logic      [15:0] phase_cur
);
  initial
  begin
    pins = 5'h0;
    cycle_tick = 1'h0;
    time_stamp = 32'h0;
    phase_cur = 16'h0;
  end
  // Stamp moves with the tick so the design sees the new value
  always @(posedge clk)
  begin
    pins <= pin_req;
    cycle_tick <= tick_req;
    phase_cur <= phase_cur + 16'h0101;
    if (tick_req)
      time_stamp <= time_stamp + 32'(TICK_US);
  end
endmodule

// ---- bench/breaker_failure_timer_logic_test.sv ----
// Bench: reset values, random pick-up walk per criterion, events, irq, log.
// Assumes the package, partner and checker compile first.
`timescale 1ns/1ns
module breaker_failure_timer_logic_test
  import breaker_fail_pkg::*;
;
  localparam int RD = 2;
  localparam int FD = 3;
  logic clk = 0, rstn = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, tick_req = 0;
  logic [ADDR_W-1:0] wb_adr = 0;
  logic [DATA_W-1:0] wb_dat_w = 0, wb_dat_r, rd;
  logic [4:0] pin_req = 0, p = 0;
  logic [7:0] mprev = 0;
  wire logic phase_over, residual_over, trip_monitor, digital_in, block_in, cycle_tick;
  wire logic [31:0] time_stamp;
  wire logic [15:0] phase_cur;
  logic wb_ack, start_output, blocked_output, retrip_output, breaker_fail_output;
  logic event_valid, event_on, event_store, irq;
  logic [2:0] event_id;
  logic [31:0] event_time;
  logic [15:0] evsel = 16'hFFFF;
  logic [7:0] ra[5] = '{OFS_CTRL, OFS_RETRIP_DELAY, OFS_CBF_DELAY, OFS_EVENT_SELECT, 8'h40};
  logic [31:0] rv[5] = '{32'h4, 32'h14, 32'h28, 32'hFFFF, 32'h0};
  int err_total = 0, comparisons = 0, cnt = 0, ntick = 0, crit = 0;
  int nocc[4] = '{0, 0, 0, 0};
  int q[$], e[$];
  breaker_failure_timer_logic #(.CNT_W(20), .CTR_W(16)) i_breaker_failure_timer_logic
  (
    .clk, .rstn, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(4'hF), .wb_dat_w, .wb_dat_r,
    .wb_ack, .phase_over, .residual_over, .trip_monitor, .digital_in, .block_in,
    .cycle_tick, .time_stamp, .phase_max_current(phase_cur), .residual_input_one(phase_cur),
    .residual_input_two(~phase_cur), .setting_group(3'h5), .start_output, .blocked_output,
    .retrip_output, .breaker_fail_output, .event_valid, .event_id, .event_on, .event_store,
    .event_time, .irq
  );
  breaker_fail_partner i_breaker_fail_partner
  (
    .clk, .tick_req, .pin_req, .cycle_tick, .time_stamp, .phase_cur,
    .pins({block_in, digital_in, trip_monitor, residual_over, phase_over})
  );
  ////////////////////////////////////////
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'h1 && n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    if (n >= 20)
    begin
      err_total++;
      $display("unexpected %0t no bus answer", $time);
    end
  endtask
  function automatic logic pick(int c, logic [4:0] v);
    case (c)
      0: return v[0] | v[1];
      1: return (v[0] | v[1]) & v[2];
      2: return v[0] | v[1] | v[2];
      default: return v[3];
    endcase
  endfunction
  // One pin change, settle, compare levels, one tick, collect the event burst
  task automatic step(input logic [4:0] v);
    logic go;
    logic [7:0] mc;
    @(posedge clk);
    pin_req <= v;
    repeat (6) @(posedge clk);
    go = pick(crit, v) & !v[4];
    if (!go)
      cnt = 0;
    chk(start_output, go, "start level");
    chk(blocked_output, pick(crit, v) & v[4], "blocked level");
    chk(retrip_output, go && cnt >= RD, "retrip level");
    chk(breaker_fail_output, go && cnt >= FD, "fail level");
    // Tick view, bit 0 up: start, retrip, fail, blocked, contact, input, phase, residual
    mc = {v[1], v[0], v[3], v[2], pick(crit, v) & v[4], go && cnt >= FD, go && cnt >= RD, go};
    tick_req <= 1'h1;
    @(posedge clk);
    tick_req <= 1'h0;
    ntick++;
    cnt += go;
    // Edges only count when a tick sees them
    nocc[0] += mc[1] & !mprev[1];
    nocc[1] += mc[2] & !mprev[2];
    nocc[2] += mc[0] & !mprev[0];
    nocc[3] += mc[3] & !mprev[3];
    e.delete();
    q.delete();
    for (int i = 0; i < 8; i++) if (mc[i] & !mprev[i]) e.push_back(i + 8);
    for (int i = 0; i < 8; i++) if (!mc[i] & mprev[i]) e.push_back(i);
    repeat (12)
    begin
      @(posedge clk);
      if (event_valid === 1'h1)
      begin
        q.push_back(event_id + (event_on ? 8 : 0));
        chk(event_time, ntick * TICK_US, "event time");
        chk(event_store, evsel[2 * event_id + !event_on], "event store");
      end
    end
    chk(q.size(), e.size(), "event count");
    foreach (e[k]) if (k < q.size()) chk(q[k], e[k], "event order");
    mprev = mc;
  endtask
  ////////////////////////////////////////
  initial
    forever #20 clk = ~clk;
  initial
  begin
    #(40 * 10000);
    err_total++;
    $display("unexpected %0t watchdog timeout", $time);
    complete_run();
  end
  initial
  begin
    void'($urandom(90768));
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    wb(1'h1, 8'h40, 32'hFFFFFFFF);
    foreach (ra[i])
    begin
      wb(1'h0, ra[i], 32'h0);
      chk(rd, rv[i], "reset or unmapped value");
    end
    evsel = 16'($urandom);
    wb(1'h1, OFS_EVENT_SELECT, {16'h0, evsel});
    wb(1'h1, OFS_RETRIP_DELAY, RD);
    wb(1'h1, OFS_CBF_DELAY, FD);
    step(5'h1);
    chk(irq, 1'h0, "masked irq");
    wb(1'h1, OFS_IRQ_MASK, 32'h40);
    wb(1'h0, OFS_IRQ_STATUS, 32'h0);
    chk(rd[6], 1'h1, "sticky phase bit");
    chk(irq, 1'h1, "unmasked irq");
    wb(1'h1, OFS_IRQ_STATUS, 32'h40);
    wb(1'h0, OFS_IRQ_MASK, 32'h0);
    chk(irq, 1'h0, "cleared irq");
    step(5'h0);
    for (crit = 0; crit < 4; crit++)
    begin
      wb(1'h1, OFS_CTRL, 32'h4 | crit);
      repeat (30)
      begin
        if ($urandom % 3 == 0)
          p = 5'($urandom);
        p[4] = ($urandom % 6 == 0);
        step(p);
      end
      step(5'h0);
    end
    for (int k = 0; k < 4; k++)
    begin
      wb(1'h0, OFS_CNT_RETRIP + 8'(4 * k), 32'h0);
      chk(rd, nocc[k], "occurrence count");
    end
    wb(1'h1, OFS_COUNT_CLEAR, 32'h2);
    wb(1'h0, OFS_CNT_CBF, 32'h0);
    chk(rd, 32'h0, "fail count cleared");
    wb(1'h0, OFS_STATUS, 32'h0);
    chk(rd[11:8], 4'hC, "log fill");
    wb(1'h1, OFS_LOG_INDEX, 32'h10);
    wb(1'h0, OFS_LOG_DATA, 32'h0);
    chk(rd[5:3], 3'h5, "log setting group");
    complete_run();
  end
endmodule
